// *** rtl/machine_mode_decode.v ***
// Decodes a stored machine code into transport behaviour flags.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ns
`include "setup_menu_consts.vh"
module machine_mode_decode (
	// Stored code
	input  wire [4:0] code_in,
	// Behaviour flags
	output reg        master_out,
	output reg        slave_out,
	output reg        open_loop_out,
	output reg        serial_out
);
	// Master codes generate timecode, slave codes read it
	always @* begin
		master_out    = (code_in == `MACH_MTC_MASTER) || (code_in == `MACH_LTC_MASTER);
		slave_out     = (code_in == `MACH_MTC_SLAVE) || (code_in == `MACH_LTC_SLAVE);
		open_loop_out = (code_in == `MACH_MMC_OPEN);
		// All serial variants share one transport path
		serial_out    = (code_in >= `MACH_SERIAL_A) && (code_in <= `MACH_SERIAL_C);
	end
endmodule // machine_mode_decode

// *** rtl/setup_menu_consts.vh ***
// Constants for the global setup menu controller: register map, fields,
// reset values and timing counts.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone slave.
`ifndef SETUP_MENU_CONSTS_VH
`define SETUP_MENU_CONSTS_VH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define REG_PANEL_EVT     8'h00
`define REG_VIEW_STATUS   8'h04
`define REG_ACTIVE_CFG    8'h08
`define REG_EDIT_VALUES   8'h0c
`define REG_MACHINE_STAT  8'h10

// ------------------------------------------------------------
// Panel event bits in REG_PANEL_EVT (write one to press)
// ------------------------------------------------------------
`define EVT_VIEW          0
`define EVT_UP            1
`define EVT_DOWN          2
`define EVT_WHEEL_CW      3
`define EVT_WHEEL_CCW     4
`define EVT_PLAY          5
`define EVT_STOP          6

// ------------------------------------------------------------
// Display views and digit fields
// ------------------------------------------------------------
`define VIEW_TIMECODE     2'h0
`define VIEW_MIXER        2'h1
`define VIEW_SETUP        2'h2
`define VIEW_LAST         2'h2
`define FIELD_CHANNEL     2'h0
`define FIELD_RATE        2'h1
`define FIELD_MACHINE     2'h2
`define FIELD_SNAPSHOT    2'h3

// ------------------------------------------------------------
// Snapshot field: 1..128, then all, then global
// ------------------------------------------------------------
`define SNAP_FIRST        8'h01
`define SNAP_LAST         8'h80
`define SNAP_ALL          8'h81
`define SNAP_GLOBAL       8'h82

// ------------------------------------------------------------
// Machine codes and frame rates
// ------------------------------------------------------------
`define MACH_MTC_MASTER   5'h00
`define MACH_MTC_SLAVE    5'h01
`define MACH_LTC_MASTER   5'h02
`define MACH_LTC_SLAVE    5'h03
`define MACH_MMC_MTC      5'h07
`define MACH_MMC_LTC      5'h08
`define MACH_MMC_OPEN     5'h09
`define MACH_SERIAL_A     5'h0e
`define MACH_SERIAL_C     5'h10
`define MACH_LAST         5'h11
`define RATE_24           2'h0
`define RATE_25           2'h1
`define RATE_30           2'h2
`define RATE_30DF         2'h3
`define RATE_RESET        `RATE_25
`define MACH_RESET        `MACH_MTC_MASTER
`define CHAN_RESET        4'h0

// ------------------------------------------------------------
// Storing message time
// ------------------------------------------------------------
`define CLK_MHZ           125
`define STORE_MSG_US      1000
`define STORE_MSG_CYCLES  (`STORE_MSG_US * `CLK_MHZ)

`endif

// *** rtl/setup_menu_ctrl.v ***
// Global setup menu controller for the machine-control panel section.
// Assumes panel events arrive as Wishbone writes and tallies as pins.
`timescale 1ns/1ns
`include "setup_menu_consts.vh"
module setup_menu_ctrl #(
	parameter STORE_CYCLES = `STORE_MSG_CYCLES
) (
	// Clock and reset
	input  wire        clk_sys_in,
	input  wire        rstn_in,
	// Wishbone slave
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	input  wire        wb_we_in,
	input  wire [7:0]  wb_adr_in,
	input  wire [3:0]  wb_sel_in,
	input  wire [31:0] wb_dat_in,
	output reg  [31:0] wb_dat_out,
	output reg         wb_ack_out,
	// Machine and timecode pins
	input  wire        ext_tc_valid_in,
	input  wire        machine_tally_play_in,
	// Indicators and live configuration
	output reg         timecode_view_indicator_out,
	output reg         setup_indicator_out,
	output reg         storing_msg_out,
	output reg  [4:0]  machine_code_out,
	output reg  [1:0]  frame_rate_out,
	output reg  [3:0]  midi_channel_out,
	output reg         tc_generate_out,
	output reg         tc_read_out,
	output reg         play_lamp_out,
	output reg         transport_play_out
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	reg  [1:0]  view;
	reg  [1:0]  field;
	reg  [7:0]  snapshot;
	reg  [4:0]  edit_machine;
	reg  [1:0]  edit_rate;
	reg  [3:0]  edit_channel;
	reg  [23:0] store_count;
	reg  [1:0]  tc_sync;
	reg  [1:0]  tally_sync;
	reg         play_latched;
	wire [7:0]  next_snapshot;
	wire [7:0]  next_machine;
	wire [7:0]  next_rate;
	wire [7:0]  next_channel;
	wire        is_master;
	wire        is_slave;
	wire        is_open;
	wire        is_serial;
	wire        global_mode;
	wire        wb_req;
	wire        evt_write;
	wire        ev_view;
	wire        ev_up;
	wire        ev_down;
	wire        ev_cw;
	wire        ev_ccw;
	wire        ev_play;
	wire        ev_stop;
	wire        in_setup;

	// ------------------------------------------------------------
	// Bus decode; ack after one cycle, dropped the cycle after
	// ------------------------------------------------------------
	assign wb_req    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign evt_write = wb_req & wb_we_in & wb_sel_in[0] & (wb_adr_in == `REG_PANEL_EVT);
	assign ev_view   = evt_write & wb_dat_in[`EVT_VIEW];
	assign ev_up     = evt_write & wb_dat_in[`EVT_UP];
	assign ev_down   = evt_write & wb_dat_in[`EVT_DOWN];
	assign ev_cw     = evt_write & wb_dat_in[`EVT_WHEEL_CW];
	assign ev_ccw    = evt_write & wb_dat_in[`EVT_WHEEL_CCW];
	assign ev_play   = evt_write & wb_dat_in[`EVT_PLAY];
	assign ev_stop   = evt_write & wb_dat_in[`EVT_STOP];
	assign in_setup  = (view == `VIEW_SETUP);
	assign global_mode = (snapshot == `SNAP_GLOBAL);

	// ------------------------------------------------------------
	// Wheel steppers, one per editable field
	// ------------------------------------------------------------
	wheel_stepper #(.WIDTH(8)) snap_step (
		.low_in   (`SNAP_FIRST),
		.high_in  (`SNAP_GLOBAL),
		.cw_in    (ev_cw),
		.ccw_in   (ev_ccw),
		.value_in (snapshot),
		.value_out(next_snapshot)
	);
	wheel_stepper #(.WIDTH(8)) mach_step (
		.low_in   (8'h00),
		.high_in  ({3'h0, `MACH_LAST}),
		.cw_in    (ev_cw),
		.ccw_in   (ev_ccw),
		.value_in ({3'h0, edit_machine}),
		.value_out(next_machine)
	);
	wheel_stepper #(.WIDTH(8)) rate_step (
		.low_in   (8'h00),
		.high_in  ({6'h00, `RATE_30DF}),
		.cw_in    (ev_cw),
		.ccw_in   (ev_ccw),
		.value_in ({6'h00, edit_rate}),
		.value_out(next_rate)
	);
	wheel_stepper #(.WIDTH(8)) chan_step (
		.low_in   (8'h00),
		.high_in  (8'h0f),
		.cw_in    (ev_cw),
		.ccw_in   (ev_ccw),
		.value_in ({4'h0, edit_channel}),
		.value_out(next_channel)
	);

	// Decode acts on the stored code only, never the one being edited,
	// so the flags stay steady while the operator turns the wheel
	machine_mode_decode mode_dec (
		.code_in      (machine_code_out),
		.master_out   (is_master),
		.slave_out    (is_slave),
		.open_loop_out(is_open),
		.serial_out   (is_serial)
	);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Two flops per pin; only the second flop feeds the mode logic
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tc_sync    <= 2'h0;
			tally_sync <= 2'h0;
		end else begin
			tc_sync    <= {tc_sync[0], ext_tc_valid_in};
			tally_sync <= {tally_sync[0], machine_tally_play_in};
		end
	end

	// ------------------------------------------------------------
	// Menu navigation and editing
	// ------------------------------------------------------------
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			view         <= `VIEW_TIMECODE;
			field        <= `FIELD_SNAPSHOT;
			snapshot     <= `SNAP_FIRST;
			edit_machine <= `MACH_RESET;
			edit_rate    <= `RATE_RESET;
			edit_channel <= `CHAN_RESET;
		end else if (ev_view) begin
			if (in_setup)
				view <= `VIEW_TIMECODE;
			else if (view == `VIEW_LAST)
				view <= `VIEW_TIMECODE;
			else
				view <= view + 2'h1;
		end else if (in_setup) begin
			// Fields run left to right: channel, rate, machine, snapshot
			// Field moves saturate at the ends instead of wrapping
			if (ev_up && field != `FIELD_SNAPSHOT)
				field <= field + 2'h1;
			else if (ev_down && field != `FIELD_CHANNEL)
				field <= field - 2'h1;
			// Machine, rate and channel edits outside the global entry are dropped, so a plain snapshot
			// page can never reach the machine driver settings
			case (field)
			`FIELD_SNAPSHOT: snapshot <= next_snapshot;
			`FIELD_MACHINE: begin
				if (global_mode)
					edit_machine <= next_machine[4:0];
			end
			`FIELD_RATE: begin
				if (global_mode)
					edit_rate <= next_rate[1:0];
			end
			`FIELD_CHANNEL: begin
				if (global_mode)
					edit_channel <= next_channel[3:0];
			end
			default: snapshot <= snapshot;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Store on leaving setup; the live copy changes only here
	// Only a view press that leaves setup restarts the count while the message shows
	// ------------------------------------------------------------
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			machine_code_out <= `MACH_RESET;
			frame_rate_out   <= `RATE_RESET;
			midi_channel_out <= `CHAN_RESET;
			storing_msg_out  <= 1'b0;
			store_count      <= 24'h000000;
		end else if (ev_view && in_setup) begin
			machine_code_out <= edit_machine;
			frame_rate_out   <= edit_rate;
			midi_channel_out <= edit_channel;
			storing_msg_out  <= 1'b1;
			store_count      <= STORE_CYCLES[23:0];
		end else if (store_count != 24'h000000) begin
			store_count <= store_count - 24'h000001;
			storing_msg_out <= (store_count != 24'h000001);
		end
	end

	// ------------------------------------------------------------
	// Transport behaviour per machine mode
	// ------------------------------------------------------------
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			play_latched       <= 1'b0;
			tc_generate_out    <= 1'b0;
			tc_read_out        <= 1'b0;
			play_lamp_out      <= 1'b0;
			transport_play_out <= 1'b0;
		end else begin
			// Outputs trail the stored code by one cycle, except transport_play_out, which trails it by two on entering a slave mode
			// Slave modes ignore the transport keys entirely
			if (!is_slave) begin
				if (ev_play)
					play_latched <= 1'b1;
				else if (ev_stop)
					play_latched <= 1'b0;
			end else begin
				play_latched <= 1'b0;
			end
			tc_generate_out    <= is_master & play_latched;
			tc_read_out        <= is_slave & tc_sync[1];
			transport_play_out <= play_latched & ~is_master;
			// Local lamps where no tally comes back from the machine
			play_lamp_out <= (is_open | is_master) ? play_latched
			               : (is_slave ? 1'b0 : tally_sync[1]);
		end
	end

	// ------------------------------------------------------------
	// Indicators
	// ------------------------------------------------------------
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			timecode_view_indicator_out <= 1'b1;
			setup_indicator_out         <= 1'b0;
		end else begin
			timecode_view_indicator_out <= (view == `VIEW_TIMECODE);
			setup_indicator_out         <= in_setup;
		end
	end

	// ------------------------------------------------------------
	// Bus answer; unmapped reads return zero
	// ------------------------------------------------------------
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			// Data is registered with ack, so it stands for that one cycle only
			wb_ack_out <= wb_req;
			wb_dat_out <= 32'h00000000;
			if (wb_req && !wb_we_in) begin
				case (wb_adr_in)
				`REG_VIEW_STATUS:
					wb_dat_out <= {15'h0000, storing_msg_out, global_mode,
						snapshot, field, view, 3'h0};
				`REG_ACTIVE_CFG:
					wb_dat_out <= {21'h000000, midi_channel_out, frame_rate_out,
						machine_code_out};
				`REG_EDIT_VALUES:
					wb_dat_out <= {21'h000000, edit_channel, edit_rate, edit_machine};
				`REG_MACHINE_STAT:
					wb_dat_out <= {24'h000000, is_serial, is_open, is_slave, is_master,
						play_lamp_out, tc_read_out, tc_generate_out, transport_play_out};
				default:
					wb_dat_out <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // setup_menu_ctrl

// *** rtl/wheel_stepper.v ***
// Wrapping up/down stepper used for every wheel-edited field.
// Assumes one-cycle pulses on the same clock.
`timescale 1ns/1ns
module wheel_stepper #(
	parameter WIDTH = 8
) (
	// Range and steps
	input  wire [WIDTH-1:0] low_in,
	input  wire [WIDTH-1:0] high_in,
	input  wire             cw_in,
	input  wire             ccw_in,
	// Value
	input  wire [WIDTH-1:0] value_in,
	output reg  [WIDTH-1:0] value_out
);
	// Clockwise wins if both arrive together; the pulses never coincide in practice
	always @* begin
		value_out = value_in;
		if (cw_in) begin
			if (value_in >= high_in)
				value_out = low_in;
			else
				value_out = value_in + {{(WIDTH-1){1'b0}}, 1'b1};
		end else if (ccw_in) begin
			if (value_in <= low_in)
				value_out = high_in;
			else
				value_out = value_in - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // wheel_stepper

// *** tb/global_setup_menu_controller_test.sv ***
// Self-checking bench for the setup menu controller.
// Assumes the design header is on the include path.
`timescale 1ns/1ns
`include "setup_menu_consts.vh"
module global_setup_menu_controller_test;
	logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, tc_src = 0;
	logic [7:0]  adr = 0;
	logic [31:0] dat_w = 0, dat_r;
	logic        ack, tc_ok, tally, tcv, setup, storing, gen, rdr, lamp, tplay;
	logic [4:0]  code;
	logic [1:0]  rate;
	logic [3:0]  chan;
	logic [63:0] q[$];
	int          n_mismatch = 0, checks_done = 0;

	always #4 clk = ~clk;

	setup_menu_ctrl #(.STORE_CYCLES(4)) i_dut (
		.clk_sys_in(clk), .rstn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat_w),
		.wb_dat_out(dat_r), .wb_ack_out(ack), .ext_tc_valid_in(tc_ok),
		.machine_tally_play_in(tally), .timecode_view_indicator_out(tcv),
		.setup_indicator_out(setup), .storing_msg_out(storing), .machine_code_out(code),
		.frame_rate_out(rate), .midi_channel_out(chan), .tc_generate_out(gen),
		.tc_read_out(rdr), .play_lamp_out(lamp), .transport_play_out(tplay));
	tape_model i_tape (.clk_in(clk), .rstn_in(rstn), .play_cmd_in(tplay),
		.tc_src_in(tc_src), .tc_valid_out(tc_ok), .tally_play_out(tally));

	// ------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One classic cycle; request held until ack is sampled high
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		{cyc, stb, we, adr, dat_w} <= {2'b11, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (n >= 40) n_mismatch++;
		{cyc, stb, dat_w} <= {2'b00, ~d}; // Stale data never looks valid
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		q.push_back({m, e & m});
		wb(a, 1'b0, 32'h0);
	endtask
	task automatic st(input logic [31:0] e, m);
		rd(`REG_VIEW_STATUS, e, m);
	endtask
	task automatic ev(input int b);
		wb(`REG_PANEL_EVT, 1'b1, 32'h1 << b);
	endtask
	// Read data checked in bus order against the driver's notes
	always @(posedge clk)
		if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
			logic [63:0] e;
			e = q.pop_front();
			chk("read data", dat_r & e[63:32], e[31:0]);
		end
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------
	// One full setup pass from reset
	// ------------------------------------------------
	task automatic pass(input logic [4:0] k, input logic [1:0] r);
		logic m, s;
		m = k == `MACH_MTC_MASTER || k == `MACH_LTC_MASTER;
		s = k == `MACH_MTC_SLAVE || k == `MACH_LTC_SLAVE;
		tc_src <= 1'b0;
		rstn <= 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		wb(`REG_ACTIVE_CFG, 1'b1, 32'h7ff); // Read-only place, must be ignored
		rd(`REG_ACTIVE_CFG, 32'h20, 32'h7ff);
		rd(8'h40, 32'h0, 32'hffffffff);
		ev(`EVT_VIEW);
		st(32'h08, 32'h18);
		ev(`EVT_VIEW);
		chk("view lamps", {setup, tcv}, 2'b10);
		ev(`EVT_WHEEL_CCW);
		st(32'hc100, 32'hff80);
		ev(`EVT_WHEEL_CW);
		st(32'h0080, 32'hff80);
		ev(`EVT_WHEEL_CCW);
		ev(`EVT_DOWN);
		st(32'h40, 32'h60);
		for (int i = 0; i < k; i++) ev(`EVT_WHEEL_CW);
		rd(`REG_EDIT_VALUES, {27'h0, k}, 32'h1f);
		rd(`REG_ACTIVE_CFG, 32'h0, 32'h1f);
		ev(`EVT_DOWN);
		st(32'h20, 32'h60);
		for (int i = 0; i < r; i++) ev(`EVT_WHEEL_CW);
		ev(`EVT_DOWN);
		ev(`EVT_DOWN);
		st(32'h00, 32'h60);
		ev(`EVT_WHEEL_CCW);
		rd(`REG_EDIT_VALUES, {21'h0, 4'hf, r + 2'h1, k}, 32'h7ff);
		ev(`EVT_UP);
		st(32'h20, 32'h60);
		ev(`EVT_UP);
		st(32'h40, 32'h60);
		ev(`EVT_VIEW);
		chk("store", {storing, tcv, setup}, 3'b110);
		chk("stored cfg", {chan, rate, code}, {4'hf, r + 2'h1, k});
		rd(`REG_ACTIVE_CFG, {21'h0, 4'hf, r + 2'h1, k}, 32'h7ff);
		tc_src <= s;
		ev(`EVT_PLAY);
		repeat (4) @(posedge clk);
		chk("modes", {gen, rdr, tplay}, {m, s, !m && !s});
		chk("lamp early", lamp, m | (k == `MACH_MMC_OPEN));
		rd(`REG_MACHINE_STAT, {24'h0, k >= `MACH_SERIAL_A && k <= `MACH_SERIAL_C,
			k == `MACH_MMC_OPEN, s, m, 4'h0}, 32'hf0);
		repeat (4) @(posedge clk);
		chk("lamp late", lamp, !s);
		ev(`EVT_STOP);
		chk("stopped", {gen, tplay}, 2'b00);
		$display("Pass with machine code %0d done", k);
	endtask

	initial begin
		void'($urandom(13));
		pass(5'($urandom % 18), 2'($urandom % 4));
		pass(`MACH_LTC_MASTER, 2'h2);
		pass(`MACH_MTC_SLAVE, 2'h3);
		pass(`MACH_MMC_OPEN, 2'h0);
		pass(`MACH_SERIAL_A, 2'h1);
		give_verdict();
	end
	// Watchdog, far beyond the fewer than a thousand cycles the passes need
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
endmodule // global_setup_menu_controller_test

// *** tb/setup_menu_checker.sv ***
// Checker for the setup menu controller: bus answer, store flow, modes.
// Bound to the top module; one clock domain, async active-low reset.
`timescale 1ns/1ns
`include "setup_menu_consts.vh"
module setup_menu_checker #(
	parameter STORE_CYCLES = 4
) (
	// Clock, reset and bus
	input logic       clk_sys_in,
	input logic       rstn_in,
	input logic       wb_cyc_in,
	input logic       wb_stb_in,
	input logic       wb_ack_out,
	// Indicators and configuration
	input logic       timecode_view_indicator_out,
	input logic       setup_indicator_out,
	input logic       storing_msg_out,
	input logic [4:0] machine_code_out,
	input logic [1:0] frame_rate_out,
	input logic [3:0] midi_channel_out,
	input logic       tc_generate_out,
	input logic       tc_read_out,
	input logic       transport_play_out
);
	int   hi_cnt;
	logic mst;
	logic slv;
	// Mode decode of the stored code; flags may lag it by up to two cycles
	assign mst = machine_code_out == `MACH_MTC_MASTER || machine_code_out == `MACH_LTC_MASTER;
	assign slv = machine_code_out == `MACH_MTC_SLAVE || machine_code_out == `MACH_LTC_SLAVE;
	// Length of the storing message, counted instead of a long repetition
	always_ff @(posedge clk_sys_in or negedge rstn_in)
		if (!rstn_in) hi_cnt <= 0;
		else hi_cnt <= storing_msg_out ? hi_cnt + 1 : 0;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("bus request not answered");
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	view_excl_a: assert property (timecode_view_indicator_out |-> !setup_indicator_out)
		else $error("two view lamps lit");
	store_msg_a: assert property ($fell(setup_indicator_out) |-> ##[0:2]
		storing_msg_out && timecode_view_indicator_out) else $error("no store on leaving setup");
	store_len_a: assert property ($fell(storing_msg_out) |-> hi_cnt == STORE_CYCLES)
		else $error("storing message length wrong");
	cfg_hold_a: assert property (!$stable({machine_code_out, frame_rate_out,
		midi_channel_out}) |-> ##[0:2] storing_msg_out) else $error("config changed unstored");
	gen_master_a: assert property (tc_generate_out |-> mst || $past(mst) || $past(mst, 2))
		else $error("timecode generated outside master mode");
	slave_quiet_a: assert property (slv && $past(slv) && $past(slv, 2) |->
		!tc_generate_out && !transport_play_out) else $error("transport active in slave mode");
	read_slave_a: assert property (tc_read_out |-> slv || $past(slv) || $past(slv, 2))
		else $error("reader active outside slave mode");
	code_range_a: assert property (machine_code_out <= `MACH_LAST)
		else $error("machine code out of range");
	cover property ($fell(storing_msg_out));
	cover property ($rose(tc_generate_out));
	cover property ($rose(tc_read_out));
endmodule // setup_menu_checker

bind setup_menu_ctrl setup_menu_checker #(.STORE_CYCLES(STORE_CYCLES)) i_chk (
	.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
	.timecode_view_indicator_out(timecode_view_indicator_out),
	.setup_indicator_out(setup_indicator_out), .storing_msg_out(storing_msg_out),
	.machine_code_out(machine_code_out), .frame_rate_out(frame_rate_out),
	.midi_channel_out(midi_channel_out), .tc_generate_out(tc_generate_out),
	.tc_read_out(tc_read_out), .transport_play_out(transport_play_out));

// *** tb/tape_model.sv ***
// Tape machine model: external timecode source and play tally.
// Assumes the bench enables the timecode source per scenario.
`timescale 1ns/1ns
module tape_model #(
	parameter LAG = 6
) (
	// Clock and reset
	input  logic clk_in,
	input  logic rstn_in,
	// Play command from the block, source enable from the bench
	input  logic play_cmd_in,
	input  logic tc_src_in,
	// Pins toward the block
	output logic tc_valid_out,
	output logic tally_play_out
);
	logic [LAG-1:0] pipe;
	// Tally lags the command: a real transport never reports play at once
	always_ff @(posedge clk_in or negedge rstn_in)
		if (!rstn_in) pipe <= '0;
		else pipe <= {pipe[LAG-2:0], play_cmd_in};
	assign tally_play_out = pipe[LAG-1];
	assign tc_valid_out   = tc_src_in;
endmodule // tape_model
